/* File: verilog/sbg_pkg.sv */
// Purpose: Shared constants and carriers for the serial baud rate generator
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package sbg_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_BAUD_HIGH = 8'h00;
    localparam logic [7:0] OFS_BAUD_LOW = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_EVENTS = 8'h14;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BRK_IE_BIT = 7;
    localparam int EDGE_IE_BIT = 6;
    localparam int HIGH_DIV_MSB = 4;
    localparam int CTL_RX_ON_BIT = 0;
    localparam int CTL_TX_ON_BIT = 1;
    localparam int CTL_POS_BIT = 2;
    localparam int EV_BRK_BIT = 0;
    localparam int EV_EDGE_BIT = 1;
    localparam int EV_RUN_BIT = 2;
    localparam int NUM_EVENTS = 3;
    localparam int DIV_W = 13;
    localparam int OVS_W = 4;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] BAUD_HIGH_RST = 8'h00;
    localparam logic [7:0] BAUD_LOW_RST = 8'h04;
    localparam logic [2:0] CONTROL_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;

    // ----------------------------------------
    // AHB encodings
    // ----------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    // Captured address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } sbg_aphase_t;

    // Routed pin group for the second port
    typedef struct packed {
        logic f0_out;
        logic f0_oe_n;
        logic e6_out;
        logic e6_oe_n;
    } sbg_pins_t;

endpackage : sbg_pkg

/* File: verilog/sbg_divider.sv */
// Purpose: Sixteen-times oversample tick divider
// Assumes: Divisor stable except at a low byte write
// Notes:   Zero divisor or disable halts all toggling
`timescale 1ns/1ps
module sbg_divider (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Control
    input wire logic run,
    input wire logic [sbg_pkg::DIV_W-1:0] divisor_value,
    // Ticks
    output logic sample_tick,
    output logic bit_tick
);

    logic [sbg_pkg::DIV_W-1:0] cnt_q;
    logic [sbg_pkg::OVS_W-1:0] ovs_q;
    logic active;
    logic wrap;

    // RULE_03: zero stops generator
    assign active = run && (divisor_value != '0);

    // Wrap at or past the end count: a divisor shrunk below the running
    // count restarts at once instead of rolling through all 8192 states
    assign wrap = active && (cnt_q >= divisor_value - 1'b1);

    // Divisor counter; held at zero when idle so nothing switches
    // RULE_09: tick per divisor count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            sample_tick <= 1'b0;
        end else if (clk_en) begin
            if (!active) begin
                cnt_q <= '0;
                sample_tick <= 1'b0;
            end else if (wrap) begin
                cnt_q <= '0;
                sample_tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
                sample_tick <= 1'b0;
            end
        end
    end

    // RULE_04: sixteen ticks per bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovs_q <= '0;
            bit_tick <= 1'b0;
        end else if (clk_en) begin
            if (!active) begin
                ovs_q <= '0;
                bit_tick <= 1'b0;
            end else begin
                bit_tick <= 1'b0;
                if (wrap) begin
                    ovs_q <= ovs_q + 1'b1;
                    bit_tick <= (ovs_q == '1);
                end
            end
        end
    end

endmodule : sbg_divider

/* File: verilog/sbg_top.sv */
// Purpose: Baud rate generator, interrupt enables and pin routing
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   Transmitter and receiver lie outside this block
//
// Contract
// RULE_01: Divisor is high register bits four to zero with low byte.
// RULE_02: High byte is buffered; working divisor changes on low byte write.
// RULE_03: A zero divisor stops the generator completely.
// RULE_04: Bit rate equals bus clock over sixteen times divisor.
// RULE_05: Low byte resets nonzero; generator idle until rx or tx enabled.
// RULE_06: High bit seven gates break detect flag onto interrupt request.
// RULE_07: High bit six gates receive edge flag onto interrupt request.
// RULE_08: Position select routes second port to port F or port E.
// RULE_09: One sample tick per divisor count, sixteen per bit.
// RULE_10: High register bit five reads zero and ignores writes.
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module sbg_top (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Receiver side flags and transmitter line
    input wire logic break_detect_flag,
    input wire logic rx_edge_flag,
    input wire logic serial_tx_data,
    // Pins: port F bit zero/one, port E bit six/seven
    output logic port_f_bit_zero_out,
    output logic port_f_bit_zero_oe_n,
    input wire logic port_f_bit_one_in,
    output logic port_e_bit_six_out,
    output logic port_e_bit_six_oe_n,
    input wire logic port_e_bit_seven_in,
    // Receive line after routing
    output logic second_serial_in_pin,
    // Baud ticks and requests
    output logic sample_tick,
    output logic bit_tick,
    output logic serial_irq,
    output logic irq
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    sbg_pkg::sbg_aphase_t ap_q;
    logic [7:0] high_buf_q;
    logic [7:0] high_work_q;
    logic [7:0] low_q;
    logic [2:0] ctl_q;
    logic [2:0] mask_q;
    logic [2:0] status_q;
    logic run_q;
    logic [sbg_pkg::DIV_W-1:0] divisor_value;
    logic [sbg_pkg::NUM_EVENTS-1:0] ev_set;
    logic [sbg_pkg::NUM_EVENTS-1:0] ev_clr;
    logic brk_q;
    logic edge_q;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_mux;
    logic start_run;

    // ----------------------------------------
    // Bus address phase capture
    // ----------------------------------------

    // Latch a valid address phase; zero wait states always
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= '0;
        end else if (clk_en) begin
            if (hready) begin
                ap_q.valid <= hsel && (htrans == sbg_pkg::HTRANS_NONSEQ ||
                                       htrans == sbg_pkg::HTRANS_SEQ);
                ap_q.write <= hwrite;
                ap_q.addr <= haddr;
            end
        end
    end

    assign wr_en = clk_en && ap_q.valid && ap_q.write;
    assign rd_en = clk_en && hready && hsel && !hwrite &&
                   (htrans == sbg_pkg::HTRANS_NONSEQ || htrans == sbg_pkg::HTRANS_SEQ);

    // Ready and response are constant: no wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------
    // Baud registers
    // ----------------------------------------

    // RULE_02: high byte buffered
    // RULE_10: bit five not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_buf_q <= sbg_pkg::BAUD_HIGH_RST;
        end else if (wr_en && ap_q.addr == sbg_pkg::OFS_BAUD_HIGH) begin
            high_buf_q <= {hwdata[7:6], 1'b0, hwdata[4:0]};
        end
    end

    // RULE_02: commit on low write
    // RULE_05: low byte resets nonzero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_work_q <= sbg_pkg::BAUD_HIGH_RST;
            low_q <= sbg_pkg::BAUD_LOW_RST;
        end else if (wr_en && ap_q.addr == sbg_pkg::OFS_BAUD_LOW) begin
            high_work_q <= high_buf_q;
            low_q <= hwdata[7:0];
        end
    end

    // RULE_01: thirteen bit divisor
    assign divisor_value = {high_work_q[sbg_pkg::HIGH_DIV_MSB:0], low_q};

    // Control register: rx_on, tx_on, pin position
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= sbg_pkg::CONTROL_RST;
        end else if (wr_en && ap_q.addr == sbg_pkg::OFS_CONTROL) begin
            ctl_q <= hwdata[2:0];
        end
    end

    // RULE_05: idle until first enable
    // Once started it stays armed; a zero divisor is the way to stop it
    assign start_run = ctl_q[sbg_pkg::CTL_RX_ON_BIT] || ctl_q[sbg_pkg::CTL_TX_ON_BIT];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 1'b0;
        end else if (clk_en && start_run) begin
            run_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Generator
    // ----------------------------------------

    // RULE_03: divider halts on zero
    sbg_divider u_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .run(run_q),
        .divisor_value(divisor_value),
        .sample_tick(sample_tick),
        .bit_tick(bit_tick)
    );

    // ----------------------------------------
    // Flag requests
    // ----------------------------------------

    // Register flags for edge detection of new events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            brk_q <= 1'b0;
            edge_q <= 1'b0;
        end else if (clk_en) begin
            brk_q <= break_detect_flag;
            edge_q <= rx_edge_flag;
        end
    end

    // RULE_06: break request gating
    // RULE_07: edge request gating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_irq <= 1'b0;
        end else if (clk_en) begin
            serial_irq <= (break_detect_flag && high_work_q[sbg_pkg::BRK_IE_BIT]) ||
                          (rx_edge_flag && high_work_q[sbg_pkg::EDGE_IE_BIT]);
        end
    end

    // ----------------------------------------
    // Sticky status, mask and interrupt
    // ----------------------------------------
    assign ev_set[sbg_pkg::EV_BRK_BIT] = break_detect_flag && !brk_q;
    assign ev_set[sbg_pkg::EV_EDGE_BIT] = rx_edge_flag && !edge_q;
    assign ev_set[sbg_pkg::EV_RUN_BIT] = start_run && !run_q;
    assign ev_clr = {sbg_pkg::NUM_EVENTS{rd_en && haddr == sbg_pkg::OFS_STATUS}};

    // Per bit sticky flag; a set in the clearing cycle wins
    generate
        for (genvar i = 0; i < sbg_pkg::NUM_EVENTS; i++) begin : g_ev
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    status_q[i] <= 1'b0;
                end else if (clk_en) begin
                    if (ev_set[i]) begin
                        status_q[i] <= 1'b1;
                    end else if (ev_clr[i]) begin
                        status_q[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Mask register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= sbg_pkg::MASK_RST;
        end else if (wr_en && ap_q.addr == sbg_pkg::OFS_MASK) begin
            mask_q <= hwdata[2:0];
        end
    end

    // Level interrupt from next status: stored flags plus new sets, less a read clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |((status_q | ev_set) & ~(ev_clr & ~ev_set) & mask_q);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------

    // Reads show the working high byte; buffered value is not visible
    always_comb begin
        rd_mux = '0;
        case (haddr)
            sbg_pkg::OFS_BAUD_HIGH: rd_mux = {24'h00_0000, high_work_q};
            sbg_pkg::OFS_BAUD_LOW: rd_mux = {24'h00_0000, low_q};
            sbg_pkg::OFS_CONTROL: rd_mux = {29'h0000_0000, ctl_q};
            sbg_pkg::OFS_STATUS: rd_mux = {29'h0000_0000, status_q};
            sbg_pkg::OFS_MASK: rd_mux = {29'h0000_0000, mask_q};
            sbg_pkg::OFS_EVENTS: rd_mux = {29'h0000_0000, run_q, rx_edge_flag,
                                           break_detect_flag};
            default: rd_mux = '0;
        endcase
    end

    // Read data registered at the address phase edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_en) begin
            hrdata <= rd_mux;
        end
    end

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------

    // RULE_08: position select routing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_f_bit_zero_out <= 1'b1;
            port_f_bit_zero_oe_n <= 1'b1;
            port_e_bit_six_out <= 1'b1;
            port_e_bit_six_oe_n <= 1'b1;
            second_serial_in_pin <= 1'b1;
        end else if (clk_en) begin
            port_f_bit_zero_out <= serial_tx_data;
            port_e_bit_six_out <= serial_tx_data;
            port_f_bit_zero_oe_n <= ctl_q[sbg_pkg::CTL_POS_BIT];
            port_e_bit_six_oe_n <= !ctl_q[sbg_pkg::CTL_POS_BIT];
            second_serial_in_pin <= ctl_q[sbg_pkg::CTL_POS_BIT] ?
                                    port_e_bit_seven_in : port_f_bit_one_in;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_zero_halts: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
        (divisor_value == '0) [*3] |-> !sample_tick)
        else $error("tick with zero divisor");

    chk_idle_reset: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
        !run_q |=> !sample_tick)
        else $error("tick before enable");

    chk_buf_commit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
        !(wr_en && ap_q.addr == sbg_pkg::OFS_BAUD_LOW) |=> $stable(high_work_q))
        else $error("working high changed without low write");

    chk_low_commit: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
        (wr_en && ap_q.addr == sbg_pkg::OFS_BAUD_LOW) |=> high_work_q == $past(high_buf_q))
        else $error("buffer not committed");

    chk_bit5_zero: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
        !high_work_q[5] && !high_buf_q[5])
        else $error("high bit five set");

    chk_brk_irq: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
        (clk_en && break_detect_flag && high_work_q[sbg_pkg::BRK_IE_BIT]) |=> serial_irq)
        else $error("break request missing");

    chk_edge_irq: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
        (clk_en && !break_detect_flag && rx_edge_flag && !high_work_q[sbg_pkg::EDGE_IE_BIT])
        |=> !serial_irq)
        else $error("edge request while disabled");

    chk_pos_route: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
        (clk_en && !ctl_q[sbg_pkg::CTL_POS_BIT]) |=> !port_f_bit_zero_oe_n)
        else $error("port F not driven at position zero");

    chk_tick_spacing: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
        (clk_en && sample_tick && divisor_value == 13'h0002 && run_q && $stable(divisor_value))
        |=> !sample_tick ##1 sample_tick)
        else $error("tick spacing wrong");

endmodule : sbg_top

/* File: dv/sbg_remote_node.sv */
// Purpose: Far end serial node that drives both candidate receive pins
// Assumes: Single bus clock, pins sampled synchronously by the block
// Notes:   Each pin carries its own pattern so routing faults show at once
`timescale 1ns/1ps
module sbg_remote_node (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Line levels towards the block
    output logic port_f_bit_one_in,
    output logic port_e_bit_seven_in
);
    // ----------------------------------------
    // Line pattern
    // ----------------------------------------
    logic [15:0] lfsr_q;

    // Pattern moves every cycle; idle level is high while in reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lfsr_q <= 16'hACE1;
            port_f_bit_one_in <= 1'b1;
            port_e_bit_seven_in <= 1'b1;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            port_f_bit_one_in <= lfsr_q[0];
            port_e_bit_seven_in <= lfsr_q[3] ^ lfsr_q[0] ^ 1'b1;
        end
    end
endmodule : sbg_remote_node

/* File: dv/sbg_top_tb.sv */
// Purpose: Self-checking bench for the baud rate generator block
// Assumes: Zero wait state slave, hready tied to the slave's hreadyout
// Notes:   Register model tracks the buffered high byte and working divisor
`timescale 1ns/1ps
module sbg_top_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000, hrdata, rv;
    logic hready, hreadyout, hresp, break_detect_flag = 1'b0, rx_edge_flag = 1'b0;
    logic serial_tx_data = 1'b1, port_f_bit_zero_out, port_f_bit_zero_oe_n;
    logic port_f_bit_one_in, port_e_bit_six_out, port_e_bit_six_oe_n, port_e_bit_seven_in;
    logic second_serial_in_pin, sample_tick, bit_tick, serial_irq, irq, prv_tx, prv_f, prv_e;
    int error_cnt = 0, total_checks = 0, cyc = 0, seed = 32'h0d1b5e90, m_buf = 0, m_hi = 0;
    int m_lo = 4, n, cnt;
    assign hready = hreadyout;
    sbg_top uut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready,
        .hwdata, .hrdata, .hreadyout, .hresp, .break_detect_flag, .rx_edge_flag,
        .serial_tx_data, .port_f_bit_zero_out, .port_f_bit_zero_oe_n, .port_f_bit_one_in,
        .port_e_bit_six_out, .port_e_bit_six_oe_n, .port_e_bit_seven_in,
        .second_serial_in_pin, .sample_tick, .bit_tick, .serial_irq, .irq);
    sbg_remote_node node (.hclk, .hresetn, .port_f_bit_one_in, .port_e_bit_seven_in);

    // ----------------------------------------
    // Clock, timeout and line history
    // ----------------------------------------
    always #2.5 hclk = ~hclk;
    // Ceiling covers the longest divisor measured three times over
    always @(posedge hclk) begin
        cyc++;
        prv_tx <= serial_tx_data;
        prv_f <= port_f_bit_one_in;
        prv_e <= port_e_bit_seven_in;
        serial_tx_data <= (($random(seed) & 1) != 0);
        if (cyc == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // One single AHB-Lite transfer; waits on hready at each phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= sbg_pkg::HTRANS_NONSEQ;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rv = hrdata;
        check(hresp, 1'b0);
    endtask : bus

    // Write plus model: low byte commits the buffered high byte
    task automatic wr(input logic [7:0] a, input int d);
        bus(a, 1'b1, d);
        if (a == sbg_pkg::OFS_BAUD_HIGH) m_buf = d & 255;
        if (a == sbg_pkg::OFS_BAUD_LOW) begin
            m_hi = m_buf;
            m_lo = d & 255;
        end
    endtask : wr

    task automatic wait_n(input int k);
        repeat (k) @(negedge hclk);
    endtask : wait_n

    task automatic next_tick();
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (sample_tick !== 1'b1 && n < 9000);
    endtask : next_tick

    // Only the first gap may straddle a divisor change; the third is judged
    task automatic gap_chk();
        repeat (3) next_tick();
        check(n, ((m_hi & 31) << 8) | m_lo);
    endtask : gap_chk

    task automatic no_ticks(input int k);
        cnt = 0;
        repeat (k) begin
            @(negedge hclk);
            cnt += (sample_tick === 1'b1);
        end
    endtask : no_ticks

    task automatic pin_chk(input logic pos);
        repeat (16) begin
            @(negedge hclk);
            check({port_f_bit_zero_oe_n, port_e_bit_six_oe_n}, {pos, ~pos});
            check(pos ? port_e_bit_six_out : port_f_bit_zero_out, prv_tx);
            check(second_serial_in_pin, pos ? prv_e : prv_f);
        end
    endtask : pin_chk

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        bus(sbg_pkg::OFS_BAUD_HIGH, 1'b0, 0);
        check(rv, m_hi);
        bus(sbg_pkg::OFS_BAUD_LOW, 1'b0, 0);
        check(rv, m_lo);
        no_ticks(200);
        check(cnt, 0);
        $display("reset and idle test done");
        // Sticky status, mask and level interrupt
        wr(sbg_pkg::OFS_MASK, 1);
        bus(sbg_pkg::OFS_STATUS, 1'b0, 0);
        check(rv, 0);
        break_detect_flag <= 1'b1;
        wait_n(3);
        check(irq, 1'b1);
        bus(sbg_pkg::OFS_STATUS, 1'b0, 0);
        check(rv, 1);
        wait_n(3);
        check(irq, 1'b0);
        wr(sbg_pkg::OFS_MASK, 0);
        rx_edge_flag <= 1'b1;
        wait_n(3);
        check(irq, 1'b0);
        bus(sbg_pkg::OFS_STATUS, 1'b0, 0);
        check(rv, 2);
        break_detect_flag <= 1'b0;
        rx_edge_flag <= 1'b0;
        $display("interrupt test done");
        // Arm by transmitter enable, default divisor
        wr(sbg_pkg::OFS_CONTROL, 2);
        // start event and raw run flag
        bus(sbg_pkg::OFS_STATUS, 1'b0, 0);
        check(rv, 4);
        bus(sbg_pkg::OFS_EVENTS, 1'b0, 0);
        check(rv, 4);
        gap_chk();
        wr(sbg_pkg::OFS_BAUD_HIGH, 8'h01);
        bus(sbg_pkg::OFS_BAUD_HIGH, 1'b0, 0);
        check(rv, m_hi);
        wr(sbg_pkg::OFS_BAUD_LOW, 8'h23);
        bus(sbg_pkg::OFS_BAUD_HIGH, 1'b0, 0);
        check(rv, m_hi);
        gap_chk();
        wr(sbg_pkg::OFS_BAUD_HIGH, 8'hFF);
        wr(sbg_pkg::OFS_BAUD_LOW, 8'h00);
        bus(sbg_pkg::OFS_BAUD_HIGH, 1'b0, 0);
        check(rv, m_hi & 8'hDF);
        gap_chk();
        wr(sbg_pkg::OFS_BAUD_HIGH, 0);
        wr(sbg_pkg::OFS_BAUD_LOW, 0);
        wait_n(2);
        no_ticks(400);
        check(cnt, 0);
        repeat (6) begin
            wr(sbg_pkg::OFS_BAUD_LOW, 1 + ($random(seed) & 31));
            gap_chk();
        end
        $display("divisor test done");
        for (int i = 0; i < 16; i++) begin
            wr(sbg_pkg::OFS_BAUD_HIGH, (i >> 2) << 6);
            wr(sbg_pkg::OFS_BAUD_LOW, 1);
            break_detect_flag <= i[0];
            rx_edge_flag <= i[1];
            wait_n(3);
            check(serial_irq, (i[0] & m_hi[7]) | (i[1] & m_hi[6]));
        end
        n = 0;
        do @(negedge hclk); while (bit_tick !== 1'b1);
        do begin
            @(negedge hclk);
            n += (sample_tick === 1'b1);
        end while (bit_tick !== 1'b1 && n < 100);
        check(n, 16);
        $display("enable and bit tick test done");
        pin_chk(1'b0);
        wr(sbg_pkg::OFS_CONTROL, 6);
        wait_n(2);
        pin_chk(1'b1);
        // Clock enable low freezes every flop except the hreadyout and hresp flop
        @(posedge hclk);
        clk_en <= 1'b0;
        wait_n(1);
        rv = {port_e_bit_six_out, second_serial_in_pin, sample_tick};
        wait_n(20);
        check({port_e_bit_six_out, second_serial_in_pin, sample_tick}, rv[2:0]);
        @(posedge hclk);
        clk_en <= 1'b1;
        $display("routing test done");
        wrap_up();
    end
endmodule : sbg_top_tb
